// >>> pbmc_top.sv
// Basic mode control register of the embedded 10/100 PHY
`timescale 1ns/100ps
`default_nettype none

module pbmc_top #(
	parameter int DEAD_CYCLES = pbmc_pkg::PBMC_DEAD_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_wr_en,
	input  wire logic        mgmt_rd_en,
	input  wire logic [15:0] mgmt_wdata,
	output var  logic [15:0] mgmt_rdata,
	output var  logic        mgmt_rd_valid,
	input  wire logic        an_began,
	input  wire logic        an_speed_100,
	input  wire logic        an_full_duplex,
	output var  logic        phy_soft_reset,
	output var  logic        an_enable,
	output var  logic        an_restart_req,
	output var  logic        loopback_en,
	output var  logic        speed_100,
	output var  logic        full_duplex,
	output var  logic        power_down,
	output var  logic        isolate,
	output var  logic        coll_test,
	output var  logic        rx_dead_time
);

	// ****************************************************
	// Access decode
	// ****************************************************
	pbmc_ctl_if ctl ();

	logic hit_ctrl;
	logic wr_ctrl;

	assign hit_ctrl = (mgmt_addr == pbmc_pkg::PBMC_OFF_CTRL);
	// Writes landing while soft reset runs are dropped
	assign wr_ctrl  = mgmt_wr_en && hit_ctrl && !ctl.srst_busy;

	// ****************************************************
	// Control fields
	// ****************************************************
	logic loop_reg;
	logic speed_reg;
	logic an_en_reg;
	logic pdown_reg;
	logic isolate_reg;
	logic duplex_reg;
	logic coll_reg;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			loop_reg <= pbmc_pkg::PBMC_RST_LOOP;
		else if (ctl.srst_busy)
			loop_reg <= pbmc_pkg::PBMC_RST_LOOP;
		else if (wr_ctrl)
			loop_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_LOOP];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			speed_reg <= pbmc_pkg::PBMC_RST_SPEED;
		else if (ctl.srst_busy)
			speed_reg <= pbmc_pkg::PBMC_RST_SPEED;
		else if (wr_ctrl)
			speed_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_SPEED];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			an_en_reg <= pbmc_pkg::PBMC_RST_AN_EN;
		else if (ctl.srst_busy)
			an_en_reg <= pbmc_pkg::PBMC_RST_AN_EN;
		else if (wr_ctrl)
			an_en_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_AN_EN];
	end

	// Register stays reachable in power-down; only the datapath sleeps
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pdown_reg <= pbmc_pkg::PBMC_RST_PDOWN;
		else if (ctl.srst_busy)
			pdown_reg <= pbmc_pkg::PBMC_RST_PDOWN;
		else if (wr_ctrl)
			pdown_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_PDOWN];
	end

	// Stored as written; keeping it zero is up to software
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			isolate_reg <= pbmc_pkg::PBMC_RST_ISOLATE;
		else if (ctl.srst_busy)
			isolate_reg <= pbmc_pkg::PBMC_RST_ISOLATE;
		else if (wr_ctrl)
			isolate_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_ISOLATE];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			duplex_reg <= pbmc_pkg::PBMC_RST_DUPLEX;
		else if (ctl.srst_busy)
			duplex_reg <= pbmc_pkg::PBMC_RST_DUPLEX;
		else if (wr_ctrl)
			duplex_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_DUPLEX];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			coll_reg <= pbmc_pkg::PBMC_RST_COLL;
		else if (ctl.srst_busy)
			coll_reg <= pbmc_pkg::PBMC_RST_COLL;
		else if (wr_ctrl)
			coll_reg <= mgmt_wdata[pbmc_pkg::PBMC_BIT_COLL];
	end

	// ****************************************************
	// Sequencers
	// ****************************************************
	assign ctl.srst_start    = wr_ctrl &&
		mgmt_wdata[pbmc_pkg::PBMC_BIT_RESET];
	// A zero written to the restart bit is simply not a request
	// A write that also turns negotiation off carries no restart
	assign ctl.restart_start = wr_ctrl &&
		mgmt_wdata[pbmc_pkg::PBMC_BIT_RESTART] &&
		mgmt_wdata[pbmc_pkg::PBMC_BIT_AN_EN];
	assign ctl.an_enable     = an_en_reg && !ctl.srst_busy;
	assign ctl.an_began      = an_began;

	// Fields are held at their defaults for the whole sequence
	pbmc_srst_seq u_srst (
		.clock (clock),
		.rst_n (rst_n),
		.ctl   (ctl.srst)
	);

	pbmc_restart_seq u_restart (
		.clock (clock),
		.rst_n (rst_n),
		.ctl   (ctl.restart)
	);

	// ****************************************************
	// Effective operating mode
	// ****************************************************
	logic speed_eff;
	logic duplex_eff;

	assign speed_eff  = an_en_reg ? an_speed_100 : speed_reg;
	assign duplex_eff = an_en_reg ? an_full_duplex
	                              : duplex_reg;

	// Registered so the mode pins never glitch as negotiation settles
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			speed_100   <= pbmc_pkg::PBMC_RST_SPEED;
			full_duplex <= pbmc_pkg::PBMC_RST_DUPLEX;
		end
		else
		begin
			speed_100   <= speed_eff;
			full_duplex <= duplex_eff;
		end
	end

	// ****************************************************
	// Mode outputs
	// ****************************************************
	// Soft reset flag lags the sequencer by one clock, like every output
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			phy_soft_reset <= 1'b0;
		else
			phy_soft_reset <= ctl.srst_busy;
	end

	// Negotiation engine sees enable and restart from flops only
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			an_enable      <= pbmc_pkg::PBMC_RST_AN_EN;
			an_restart_req <= 1'b0;
		end
		else
		begin
			an_enable      <= an_en_reg;
			an_restart_req <= ctl.restart_pending;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loopback_en <= pbmc_pkg::PBMC_RST_LOOP;
			coll_test   <= pbmc_pkg::PBMC_RST_COLL;
		end
		else
		begin
			loopback_en <= loop_reg;
			coll_test   <= coll_reg;
		end
	end

	// Isolate is passed on as written; keeping it clear is up to software
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_down <= pbmc_pkg::PBMC_RST_PDOWN;
			isolate    <= pbmc_pkg::PBMC_RST_ISOLATE;
		end
		else
		begin
			power_down <= pdown_reg;
			isolate    <= isolate_reg;
		end
	end

	// ****************************************************
	// Loop-back dead interval
	// ****************************************************
	// Receive is held off while the descrambler relocks at 100 Mbps
	logic                                  loop_d_reg;
	logic [pbmc_pkg::PBMC_DEAD_CNT_W-1:0]  dead_cnt_reg;
	logic                                  dead_start;

	assign dead_start = loop_reg && !loop_d_reg && speed_eff;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			loop_d_reg <= pbmc_pkg::PBMC_RST_LOOP;
		else
			loop_d_reg <= loop_reg;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dead_cnt_reg <= '0;
			rx_dead_time <= 1'b0;
		end
		else if (dead_start)
		begin
			dead_cnt_reg <= pbmc_pkg::PBMC_DEAD_CNT_W'(DEAD_CYCLES - 1);
			rx_dead_time <= 1'b1;
		end
		else if (!loop_reg || ctl.srst_busy)
		begin
			dead_cnt_reg <= '0;
			rx_dead_time <= 1'b0;
		end
		else if (dead_cnt_reg != '0)
			dead_cnt_reg <= dead_cnt_reg - 1'b1;
		else
			rx_dead_time <= 1'b0;
	end

	// ****************************************************
	// Read path
	// ****************************************************
	function automatic logic [15:0] pbmc_ctrl_word(
		input logic rst_b,
		input logic rstrt_b
	);
		logic [15:0] w;
		w                              = 16'h0000;
		w[pbmc_pkg::PBMC_BIT_RESET]    = rst_b;
		w[pbmc_pkg::PBMC_BIT_LOOP]     = loop_reg;
		w[pbmc_pkg::PBMC_BIT_SPEED]    = speed_eff;
		w[pbmc_pkg::PBMC_BIT_AN_EN]    = an_en_reg;
		w[pbmc_pkg::PBMC_BIT_PDOWN]    = pdown_reg;
		w[pbmc_pkg::PBMC_BIT_ISOLATE]  = isolate_reg;
		w[pbmc_pkg::PBMC_BIT_RESTART]  = rstrt_b;
		w[pbmc_pkg::PBMC_BIT_DUPLEX]   = duplex_eff;
		w[pbmc_pkg::PBMC_BIT_COLL]     = coll_reg;
		return w;
	endfunction : pbmc_ctrl_word

	// A read in the cycle of a write still returns the old word
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mgmt_rdata    <= 16'h0000;
			mgmt_rd_valid <= 1'b0;
		end
		else
		begin
			mgmt_rd_valid <= mgmt_rd_en;
			if (mgmt_rd_en && hit_ctrl)
				mgmt_rdata <= pbmc_ctrl_word(ctl.srst_busy,
					ctl.restart_pending);
			else if (mgmt_rd_en)
				mgmt_rdata <= 16'h0000;
		end
	end

endmodule : pbmc_top

`default_nettype wire

// >>> pbmc_pkg.sv
// Constants and types for the PHY basic mode control register block
// Summary of operation
// - Reset bit restores defaults, self-clears when done
// - Loop-back bit enables loop-back, resets zero
// - Loop-back at 100 Mbps gives dead interval
// - Speed bit: one 100 Mbps, resets one
// - With auto-negotiation, speed reads negotiated value
// - Auto-negotiation enable resets one, overrides bits
// - Power-down bit; management still serviced
// - Restart bit reads one until negotiation begins
// - Restart ignored while auto-negotiation disabled
// - Clearing restart never aborts running negotiation
// - Duplex bit full when one, resets one
// - With auto-negotiation, duplex reads negotiated value
// - Collision test asserts collision while transmitting
// - Seven low reserved bits read zero

package pbmc_pkg;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam logic [4:0] PBMC_ADDR_W   = 5'd5;
	localparam logic [4:0] PBMC_OFF_CTRL = 5'h00;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int PBMC_BIT_RESET   = 15;
	localparam int PBMC_BIT_LOOP    = 14;
	localparam int PBMC_BIT_SPEED   = 13;
	localparam int PBMC_BIT_AN_EN   = 12;
	localparam int PBMC_BIT_PDOWN   = 11;
	localparam int PBMC_BIT_ISOLATE = 10;
	localparam int PBMC_BIT_RESTART = 9;
	localparam int PBMC_BIT_DUPLEX  = 8;
	localparam int PBMC_BIT_COLL    = 7;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic PBMC_RST_LOOP    = 1'b0;
	localparam logic PBMC_RST_SPEED   = 1'b1;
	localparam logic PBMC_RST_AN_EN   = 1'b1;
	localparam logic PBMC_RST_PDOWN   = 1'b0;
	localparam logic PBMC_RST_ISOLATE = 1'b0;
	localparam logic PBMC_RST_DUPLEX  = 1'b1;
	localparam logic PBMC_RST_COLL    = 1'b0;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int PBMC_CLK_PERIOD_NS = 8;
	localparam int PBMC_DEAD_TIME_MS  = 720;
	localparam int PBMC_DEAD_CYCLES   =
		(PBMC_DEAD_TIME_MS * 1000000) / PBMC_CLK_PERIOD_NS;
	localparam int PBMC_DEAD_CNT_W    = 27;
	localparam logic [4:0] PBMC_SRST_CYCLES = 5'd16;

	typedef enum logic [1:0] {
		PBMC_SR_IDLE,
		PBMC_SR_RUN,
		PBMC_SR_DONE
	} pbmc_srst_state_t;

endpackage : pbmc_pkg

// >>> pbmc_ctl_if.sv
// Control carrier between the register block and its sequencers
`timescale 1ns/100ps
`default_nettype none

interface pbmc_ctl_if;
	logic srst_start;
	logic srst_busy;
	logic restart_start;
	logic restart_pending;
	logic an_enable;
	logic an_began;

	modport top (
		output srst_start,
		input  srst_busy,
		output restart_start,
		input  restart_pending,
		output an_enable,
		output an_began
	);
	modport srst (
		input  srst_start,
		output srst_busy
	);
	modport restart (
		input  restart_start,
		output restart_pending,
		input  an_enable,
		input  an_began
	);
endinterface : pbmc_ctl_if

`default_nettype wire

// >>> pbmc_srst_seq.sv
// Software reset sequencer for the basic mode control register
`timescale 1ns/100ps
`default_nettype none

module pbmc_srst_seq (
	input  wire logic clock,
	input  wire logic rst_n,
	pbmc_ctl_if.srst  ctl
);
	pbmc_pkg::pbmc_srst_state_t state_reg;
	logic [4:0]                 cnt_reg;

	// Busy through the whole sequence, so the bit reads one until done
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= pbmc_pkg::PBMC_SR_IDLE;
			cnt_reg   <= 5'h00;
		end
		else
		begin
			unique case (state_reg)
				pbmc_pkg::PBMC_SR_IDLE:
				begin
					cnt_reg <= 5'h00;
					if (ctl.srst_start)
						state_reg <= pbmc_pkg::PBMC_SR_RUN;
				end
				pbmc_pkg::PBMC_SR_RUN:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == pbmc_pkg::PBMC_SRST_CYCLES - 5'h01)
						state_reg <= pbmc_pkg::PBMC_SR_DONE;
				end
				pbmc_pkg::PBMC_SR_DONE:
					state_reg <= pbmc_pkg::PBMC_SR_IDLE;
				default:
					state_reg <= pbmc_pkg::PBMC_SR_IDLE;
			endcase
		end
	end

	assign ctl.srst_busy = (state_reg != pbmc_pkg::PBMC_SR_IDLE);

endmodule : pbmc_srst_seq

`default_nettype wire

// >>> pbmc_restart_seq.sv
// Auto-negotiation restart handshake for the basic mode control register
`timescale 1ns/100ps
`default_nettype none

module pbmc_restart_seq (
	input  wire logic   clock,
	input  wire logic   rst_n,
	pbmc_ctl_if.restart ctl
);
	logic pending_reg;

	// Cleared only when the negotiation engine starts, negotiation is off or a soft reset runs; a zero write cannot
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pending_reg <= 1'b0;
		else if (ctl.restart_start)
			pending_reg <= 1'b1;
		else if (!ctl.an_enable)
			pending_reg <= 1'b0;
		else if (ctl.an_began)
			pending_reg <= 1'b0;
	end

	assign ctl.restart_pending = pending_reg;

endmodule : pbmc_restart_seq

`default_nettype wire

// >>> pbmc_props.sv
// Assertion checker for the basic mode control register
`timescale 1ns/100ps
`default_nettype none

module pbmc_props #(
	parameter int DEAD_CYCLES = 20
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [4:0]  mgmt_addr,
	input wire logic        mgmt_wr_en,
	input wire logic        mgmt_rd_en,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic        mgmt_rd_valid,
	input wire logic        an_began,
	input wire logic        an_speed_100,
	input wire logic        an_full_duplex,
	input wire logic        phy_soft_reset,
	input wire logic        an_enable,
	input wire logic        an_restart_req,
	input wire logic        loopback_en,
	input wire logic        speed_100,
	input wire logic        full_duplex,
	input wire logic        power_down,
	input wire logic        coll_test,
	input wire logic        rx_dead_time
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_RDV: assert property (mgmt_rd_en |=> mgmt_rd_valid)
		else $error("read not answered");
	AST_RSV: assert property (mgmt_rd_valid |-> mgmt_rdata[6:0] == 7'h00)
		else $error("reserved bits not zero");
	AST_NEG: assert property (mgmt_rd_valid && mgmt_rdata[12] |->
		mgmt_rdata[13] == $past(an_speed_100)
		&& mgmt_rdata[8] == $past(an_full_duplex))
		else $error("negotiated value not read");
	AST_SPD: assert property (an_enable && $past(rst_n)
		&& $stable(an_speed_100) && $stable(an_full_duplex)
		|-> speed_100 == an_speed_100 && full_duplex == an_full_duplex)
		else $error("negotiated mode not applied");
	AST_WR: assert property ((mgmt_wr_en && mgmt_addr == 5'h00
		&& !mgmt_wdata[15] && !mgmt_wdata[12] && !phy_soft_reset)
		##1 !phy_soft_reset |=> {loopback_en, speed_100, power_down,
		full_duplex, coll_test} == {$past(mgmt_wdata[14:13], 2),
		$past(mgmt_wdata[11], 2), $past(mgmt_wdata[8:7], 2)})
		else $error("written mode not applied");
	AST_RSA: assert property (!an_enable [*3] |-> !an_restart_req)
		else $error("restart while disabled");
	AST_RSB: assert property (an_restart_req && $rose(an_began)
		|-> ##2 !an_restart_req)
		else $error("restart not cleared");
	AST_SRS: assert property ($rose(phy_soft_reset)
		|-> phy_soft_reset [*8] ##[8:11] !phy_soft_reset)
		else $error("soft reset length wrong");
	AST_DEF: assert property ($fell(phy_soft_reset) |-> an_enable
		&& !loopback_en && !power_down && !coll_test)
		else $error("defaults not restored");
	AST_DED: assert property ($rose(rx_dead_time)
		|-> loopback_en && speed_100)
		else $error("dead time without loop-back");
endmodule : pbmc_props

bind pbmc_top pbmc_props #(.DEAD_CYCLES(DEAD_CYCLES)) u_props (
	.clock(clock), .rst_n(rst_n), .mgmt_addr(mgmt_addr),
	.mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
	.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
	.mgmt_rd_valid(mgmt_rd_valid), .an_began(an_began),
	.an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
	.phy_soft_reset(phy_soft_reset), .an_enable(an_enable),
	.an_restart_req(an_restart_req), .loopback_en(loopback_en),
	.speed_100(speed_100), .full_duplex(full_duplex),
	.power_down(power_down), .coll_test(coll_test),
	.rx_dead_time(rx_dead_time));

`default_nettype wire

// >>> pbmc_an_model.sv
// Negotiation engine model facing the control register
`timescale 1ns/100ps
`default_nettype none

module pbmc_an_model #(
	parameter int LAT = 5
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic restart_req,
	input  wire logic res_spd,
	input  wire logic res_fdx,
	output var  logic began,
	output var  logic spd,
	output var  logic fdx
);
	int cnt;

	// One start pulse per request; the count runs on so it never repeats
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			began <= 1'b0;
			spd <= 1'b0;
			fdx <= 1'b0;
		end
		else
		begin
			cnt <= restart_req ? cnt + 1 : 0;
			began <= restart_req && cnt == LAT - 1;
			spd <= res_spd;
			fdx <= res_fdx;
		end
	end
endmodule : pbmc_an_model

`default_nettype wire

// >>> phy_basic_mode_control_bench.sv
// Self-checking bench for the basic mode control register
`timescale 1ns/100ps
`default_nettype none

module phy_basic_mode_control_bench;
	logic        clock;
	logic        rst_n;
	logic [4:0]  addr;
	logic        wr_en;
	logic        rd_en;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rd_valid;
	logic        began;
	logic        nspd;
	logic        nfdx;
	logic        rspd;
	logic        rfdx;
	logic        sreset;
	logic        an_en;
	logic        rreq;
	logic        loop;
	logic        spd;
	logic        fdx;
	logic        pdn;
	logic        coll;
	logic        dead;
	logic        iso;
	logic [15:0] rv;
	logic [15:0] tbl [3];
	int          n_fail;
	int          tests_run;
	int          cyc;
	int          k;

	pbmc_top #(.DEAD_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n),
		.mgmt_addr(addr), .mgmt_wr_en(wr_en), .mgmt_rd_en(rd_en),
		.mgmt_wdata(wdata), .mgmt_rdata(rdata), .mgmt_rd_valid(rd_valid),
		.an_began(began), .an_speed_100(nspd), .an_full_duplex(nfdx),
		.phy_soft_reset(sreset), .an_enable(an_en),
		.an_restart_req(rreq), .loopback_en(loop), .speed_100(spd),
		.full_duplex(fdx), .power_down(pdn), .isolate(iso),
		.coll_test(coll), .rx_dead_time(dead));

	pbmc_an_model u_an (.clock(clock), .rst_n(rst_n), .restart_req(rreq),
		.res_spd(rspd), .res_fdx(rfdx), .began(began), .spd(nspd),
		.fdx(nfdx));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		rd_en = 1'b0;
		@(posedge clock);
		#1;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		addr = a;
		rd_en = 1'b1;
		wr_en = 1'b0;
		@(posedge clock);
		#1;
		chk(rd_valid, 1'b1);
		d = rdata;
	endtask : rd

	task automatic idle(input int n);
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (n) @(posedge clock);
		#1;
	endtask : idle

	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		rspd = 1'b0;
		rfdx = 1'b0;
		idle(20);
		rst_n = 1'b1;
		rd(5'h00, rv);
		chk(rv, 16'h1000);
		chk({spd, fdx, an_en}, 3'h1);
		rd(5'h01, rv);
		chk(rv, 16'h0000);
		$display("test defaults done");
		// Isolate never set by the management side
		tbl = '{16'h227f, 16'h4980, 16'h0880};
		foreach (tbl[i])
		begin
			wr(5'h00, tbl[i]);
			rd(5'h00, rv);
			chk(rv, tbl[i] & 16'h6980);
			chk({loop, spd, pdn, fdx, coll}, {tbl[i][14:13], tbl[i][11],
				tbl[i][8:7]});
			chk(iso, tbl[i][10]);
		end
		$display("test manual done");
		wr(5'h00, 16'h2000);
		idle(1);
		wr(5'h00, 16'h6000);
		k = 0;
		repeat (30)
		begin
			idle(1);
			if (dead === 1'b1)
				k++;
		end
		chk(k[15:0], 16'h0014);
		wr(5'h00, 16'h2000);
		$display("test dead time done");
		wr(5'h00, 16'h1000);
		wr(5'h00, 16'h1200);
		wr(5'h00, 16'h1000);
		rd(5'h00, rv);
		chk(rv[9], 1'b1);
		chk(rreq, 1'b1);
		rspd = 1'b1;
		rfdx = 1'b1;
		idle(12);
		rd(5'h00, rv);
		chk(rv, 16'h3100);
		$display("test restart done");
		wr(5'h00, 16'h0880);
		wr(5'h00, 16'h8000);
		rd(5'h00, rv);
		chk(rv[15], 1'b1);
		chk(sreset, 1'b1);
		wr(5'h00, 16'h4000);
		idle(20);
		rd(5'h00, rv);
		chk(rv, 16'h3100);
		chk(sreset, 1'b0);
		$display("test soft reset done");
		stop_test();
	end
endmodule : phy_basic_mode_control_bench

`default_nettype wire
